//--- hdl/kwdt_core.sv
// keyed watchdog timer: mode write-once, clear key, forced overflow
`timescale 1ns/1ps
// Functional notes
// - after reset the watchdog counts by itself in reset-on-overflow mode
// - reset default: reset mode, interval clock divided by two to the 25
// - mode value 1F halts the counter, disabling the watchdog
// - second mode write after reset forces an overflow at once
// - while stopped, neither second mode write nor bad key forces overflow
// - key write other than AC forces an overflow at once
// - single-bit operation on the key register forces an overflow
// - key register always reads back 9A
module kwdt_core #(
  parameter int CNT_W = 32,
  parameter int BASE_EXP = kwdt_pkg::DEFAULT_EXP - 7
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic mode_wr,
  input wire logic [7:0] mode_wr_data,
  input wire logic key_wr,
  input wire logic [7:0] key_wr_data,
  input wire logic key_bit_op,
  output logic [7:0] key_rd_data,
  output logic [7:0] mode_rd_data,
  output logic watchdog_overflow_nmi,
  output logic reset_request,
  output logic running
);
  // ****************************************
  // configuration state
  // ****************************************
  kwdt_pkg::kwdt_cfg_type cfg_r;
  kwdt_pkg::kwdt_cfg_type cfg_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic stopped;
  logic force_ovf;
  logic key_ok;
  logic expire;
  logic [kwdt_pkg::EXP_W-1:0] exp_sel;

  assign stopped = (mode_r == kwdt_pkg::STOP_VALUE);
  assign key_ok = key_wr && !key_bit_op && (key_wr_data == kwdt_pkg::KEY_VALUE);
  assign force_ovf = !stopped && ((mode_wr && cfg_r == kwdt_pkg::KWDT_CFG_DONE)
    || (key_wr && !key_ok));
  assign exp_sel = kwdt_pkg::EXP_W'(BASE_EXP)
    + kwdt_pkg::EXP_W'(mode_r[kwdt_pkg::SEL_LSB +: kwdt_pkg::SEL_W]);

  always_comb begin
    cfg_nxt = cfg_r;
    mode_nxt = mode_r;
    case (cfg_r)
      kwdt_pkg::KWDT_CFG_OPEN: begin
        if (mode_wr) begin
          mode_nxt = mode_wr_data;
          cfg_nxt = kwdt_pkg::KWDT_CFG_DONE;
        end
      end
      kwdt_pkg::KWDT_CFG_DONE: begin
        cfg_nxt = kwdt_pkg::KWDT_CFG_DONE;
      end
      default: begin
        cfg_nxt = kwdt_pkg::KWDT_CFG_DONE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfg_r <= kwdt_pkg::KWDT_CFG_OPEN;
      mode_r <= kwdt_pkg::MODE_RESET_VALUE;
    end else begin
      cfg_r <= cfg_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ****************************************
  // interval counter
  // ****************************************
  kwdt_interval_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(!stopped),
    .clear(key_ok || stopped || mode_wr),
    .exp_sel(exp_sel),
    .expire(expire)
  );

  // ****************************************
  // outputs
  // ****************************************
  logic ovf_r;
  logic ovf_nxt;
  logic rst_r;
  logic rst_nxt;
  logic run_r;
  logic run_nxt;
  logic [7:0] key_rd_r;
  logic [7:0] mode_rd_r;

  always_comb begin
    ovf_nxt = 1'b0;
    rst_nxt = 1'b0;
    run_nxt = !stopped;
    if (force_ovf || (expire && !stopped)) begin
      if (mode_r[kwdt_pkg::MODE_RESET_BIT]) begin
        rst_nxt = 1'b1;
      end else begin
        ovf_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ovf_r <= 1'b0;
      rst_r <= 1'b0;
      run_r <= 1'b0;
      key_rd_r <= kwdt_pkg::KEY_READ_VALUE;
      mode_rd_r <= kwdt_pkg::MODE_RESET_VALUE;
    end else begin
      ovf_r <= ovf_nxt;
      rst_r <= rst_nxt;
      run_r <= run_nxt;
      key_rd_r <= kwdt_pkg::KEY_READ_VALUE;
      mode_rd_r <= mode_nxt;
    end
  end

  assign watchdog_overflow_nmi = ovf_r;
  assign reset_request = rst_r;
  assign running = run_r;
  assign key_rd_data = key_rd_r;
  assign mode_rd_data = mode_rd_r;

  // ****************************************
  // checks
  // ****************************************
  logic any_ovf;
  assign any_ovf = ovf_r || rst_r;

  a_second_mode_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode_wr && cfg_r == kwdt_pkg::KWDT_CFG_DONE && !stopped |=> any_ovf)
    else $error("second mode write did not force overflow");
  a_bad_key_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    key_wr && key_wr_data != kwdt_pkg::KEY_VALUE && !stopped |=> any_ovf)
    else $error("bad key did not force overflow");
  a_bit_op_key: assert property (@(posedge core_clk) disable iff (!reset_n)
    key_wr && key_bit_op && !stopped |=> any_ovf)
    else $error("bit operation on key did not force overflow");
  a_stopped_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    stopped && $stable(mode_r) |=> !any_ovf)
    else $error("overflow raised while stopped");
  a_key_readback: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 key_rd_data == kwdt_pkg::KEY_READ_VALUE)
    else $error("key readback not constant");
  a_stop_halts: assert property (@(posedge core_clk) disable iff (!reset_n)
    cfg_r == kwdt_pkg::KWDT_CFG_OPEN && mode_wr && mode_wr_data == kwdt_pkg::STOP_VALUE
    |=> ##1 !running)
    else $error("stop value did not halt watchdog");
  a_reset_default: assert property (@(posedge core_clk)
    !reset_n |=> mode_r == kwdt_pkg::MODE_RESET_VALUE && cfg_r == kwdt_pkg::KWDT_CFG_OPEN)
    else $error("reset default mode wrong");
  a_good_key_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    key_ok && !mode_wr && !expire |=> !any_ovf ##1 (any_ovf == $past(force_ovf)))
    else $error("valid key raised overflow");
  a_mode_locked: assert property (@(posedge core_clk) disable iff (!reset_n)
    cfg_r == kwdt_pkg::KWDT_CFG_DONE |=> $stable(mode_r))
    else $error("mode changed after first write");

  // ****************************************
  // further checks
  // ****************************************
  // outputs and readback right after a reset edge
  a_reset_outputs: assert property (@(posedge core_clk)
    !reset_n |=> !any_ovf && !running && key_rd_data == kwdt_pkg::KEY_READ_VALUE)
    else $error("outputs not idle after reset");
  a_running_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    !stopped |=> running)
    else $error("watchdog not running");
  a_stopped_no_run: assert property (@(posedge core_clk) disable iff (!reset_n)
    stopped |=> !running)
    else $error("running while stopped");
  a_stopped_no_expire: assert property (@(posedge core_clk) disable iff (!reset_n)
    stopped |=> !expire)
    else $error("counter expired while stopped");
  a_stop_clears_count: assert property (@(posedge core_clk) disable iff (!reset_n)
    stopped |=> u_counter.cnt_r == '0)
    else $error("counter moved while stopped");
  // first mode write is stored, later ones are not
  a_mode_first_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    cfg_r == kwdt_pkg::KWDT_CFG_OPEN && mode_wr |=> mode_r == $past(mode_wr_data) && cfg_r == kwdt_pkg::KWDT_CFG_DONE)
    else $error("first mode write not stored");
  a_mode_rd_matches: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode_rd_data == mode_r)
    else $error("mode readback differs from mode");
  // expiry picks its output from the reset-action bit
  a_expiry_reset_mode: assert property (@(posedge core_clk) disable iff (!reset_n)
    expire && !stopped && mode_r[kwdt_pkg::MODE_RESET_BIT] |=> reset_request)
    else $error("expiry in reset mode gave no reset request");
  a_expiry_int_mode: assert property (@(posedge core_clk) disable iff (!reset_n)
    expire && !stopped && !mode_r[kwdt_pkg::MODE_RESET_BIT] |=> watchdog_overflow_nmi)
    else $error("expiry in interrupt mode gave no overflow");
  a_ovf_exclusive: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(watchdog_overflow_nmi && reset_request))
    else $error("both overflow outputs high");
  // every overflow pulse has a cause one cycle earlier
  a_ovf_has_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
    any_ovf |-> $past(force_ovf || (expire && !stopped)))
    else $error("overflow without cause");
  a_good_key_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    key_ok |=> u_counter.cnt_r == '0)
    else $error("valid key did not clear counter");
  a_bitop_good_key: assert property (@(posedge core_clk) disable iff (!reset_n)
    key_wr && key_bit_op && key_wr_data == kwdt_pkg::KEY_VALUE && !stopped |=> any_ovf)
    else $error("bit operation with valid key did not force overflow");
  // stopped watchdog ignores every forcing write
  a_stopped_key_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    stopped && key_wr && !key_ok |=> !any_ovf)
    else $error("bad key forced overflow while stopped");
  a_stopped_mode_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    stopped && mode_wr |=> !any_ovf)
    else $error("mode write forced overflow while stopped");
endmodule

//--- hdl/kwdt_interval_counter.sv
// interval counter with run enable, clear and expiry pulse
`timescale 1ns/1ps
module kwdt_interval_counter #(
  parameter int CNT_W = 32
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic clear,
  input wire logic [kwdt_pkg::EXP_W-1:0] exp_sel,
  output logic expire
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic expire_r;
  logic expire_nxt;
  logic [CNT_W-1:0] last;

  assign last = (CNT_W'(1) << exp_sel) - CNT_W'(1);
  assign expire = expire_r;

  always_comb begin
    cnt_nxt = cnt_r;
    expire_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = '0;
    end else if (run) begin
      if (cnt_r == last) begin
        cnt_nxt = '0;
        expire_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_r <= '0;
      expire_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expire_r <= expire_nxt;
    end
  end
endmodule

//--- hdl/kwdt_pkg.sv
// constants and types for the keyed watchdog timer
package kwdt_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] STOP_VALUE = 8'h1F;
  localparam logic [7:0] KEY_VALUE = 8'hAC;
  localparam logic [7:0] KEY_READ_VALUE = 8'h9A;
  // mode layout: bit 7 selects reset action, bits 2:0 pick the interval
  localparam int MODE_RESET_BIT = 7;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam logic [7:0] MODE_RESET_VALUE = 8'h87;
  localparam int DEFAULT_EXP = 25;
  localparam int EXP_W = 6;
  typedef enum logic [0:0] {
    KWDT_CFG_OPEN,
    KWDT_CFG_DONE
  } kwdt_cfg_type;
endpackage

//--- tb/keyed_watchdog_timer_tb.sv
// self-checking bench for the keyed watchdog core
`timescale 1ns/1ps
`define CHK(a, e) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("[ERR] %0t value mismatch", $time); \
  end \
end
module keyed_watchdog_timer_tb;
  logic core_clk = 1'b0;
  logic reset_n;
  logic mode_wr;
  logic [7:0] mode_wr_data;
  logic key_wr;
  logic [7:0] key_wr_data;
  logic key_bit_op;
  logic [7:0] key_rd_data;
  logic [7:0] mode_rd_data;
  logic watchdog_overflow_nmi;
  logic reset_request;
  logic running;
  logic [1:0] exp_q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  logic [7:0] v;
  always #10 core_clk = ~core_clk;
  // base exponent 0: default interval is 128 cycles
  kwdt_core #(.CNT_W(32), .BASE_EXP(0)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .mode_wr(mode_wr), .mode_wr_data(mode_wr_data),
    .key_wr(key_wr), .key_wr_data(key_wr_data), .key_bit_op(key_bit_op), .key_rd_data(key_rd_data),
    .mode_rd_data(mode_rd_data), .watchdog_overflow_nmi(watchdog_overflow_nmi),
    .reset_request(reset_request), .running(running)
  );
  // ************
  // tasks
  // ************
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task do_reset;
    @(posedge core_clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(running, 1'b1)
    `CHK(mode_rd_data, 8'h87)
  endtask
  task wr(input logic is_mode, input logic [7:0] d, input logic bit_op);
    @(posedge core_clk);
    #1;
    if (is_mode) begin
      mode_wr = 1'b1;
      mode_wr_data = d;
    end else begin
      key_wr = 1'b1;
      key_wr_data = d;
      key_bit_op = bit_op;
    end
    @(posedge core_clk);
    #1;
    mode_wr = 1'b0;
    key_wr = 1'b0;
    key_bit_op = 1'b0;
  endtask
  task flush;
    int i;
    for (i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge core_clk);
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("[ERR] %0t expected pulse missing", $time);
      tally_and_finish();
    end
  endtask
  function logic [7:0] bad_key;
    logic [7:0] k;
    do k = 8'($urandom); while (k == 8'hAC);
    return k;
  endfunction
  // ************
  // output monitor
  // ************
  always @(negedge core_clk) begin
    if (reset_n === 1'b1 && (reset_request | watchdog_overflow_nmi) === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        `CHK({reset_request, watchdog_overflow_nmi}, exp_q.pop_front())
      end
    end
  end
  // ************
  // main sequence
  // ************
  initial begin
    reset_n = 1'b0;
    mode_wr = 1'b0;
    mode_wr_data = 8'h00;
    key_wr = 1'b0;
    key_wr_data = 8'h00;
    key_bit_op = 1'b0;
    void'($urandom(3395));
    do_reset();
    `CHK(key_rd_data, 8'h9A)
    exp_q.push_back(2'b10);
    flush();
    do_reset();
    repeat (4) begin
      exp_q.push_back(2'b10);
      wr(1'b0, bad_key(), 1'b0);
    end
    flush();
    repeat (3) begin
      wr(1'b0, 8'hAC, 1'b0);
      repeat (100) @(posedge core_clk);
    end
    exp_q.push_back(2'b10);
    wr(1'b0, 8'hAC, 1'b1);
    flush();
    `CHK(key_rd_data, 8'h9A)
    do_reset();
    wr(1'b1, 8'h07, 1'b0);
    exp_q.push_back(2'b01);
    wr(1'b1, 8'($urandom), 1'b0);
    flush();
    `CHK(mode_rd_data, 8'h07)
    do_reset();
    wr(1'b1, 8'h1F, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(running, 1'b0)
    wr(1'b1, 8'($urandom), 1'b0);
    wr(1'b0, bad_key(), 1'b0);
    wr(1'b0, 8'hAC, 1'b1);
    repeat (300) @(posedge core_clk);
    #1;
    `CHK(running, 1'b0)
    tally_and_finish();
  end
endmodule
